// file: verif/dual_clock_fifo_with_flags_bench.sv
// Self-checking bench for the buffer, depth cut to 16 words.
// Assumes pin_partner makes the pin clocks and the data bus.
`timescale 1ns/10ps
module dual_clock_fifo_with_flags_bench
   import fifo_pkg::*;
   ;
   typedef struct {int nw; int nr; logic [3:0] fl;} row_type;
   // Words written, words read, then {empty, almost empty, almost full, full}
   row_type rows[9] = '{'{1, 0, 4'hb}, '{6, 0, 4'hb}, '{1, 0, 4'hf}, '{1, 0, 4'hd},
      '{8, 0, 4'hc}, '{0, 8, 4'hf}, '{4, 4, 4'hf}, '{0, 8, 4'h3}, '{0, 1, 4'h3}};
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reset_n = 1'b0, offset_load = 1'b0;
   logic write_enable_primary_n = 1'b1, write_enable_or_load = 1'b1;
   logic read_enable_a_n = 1'b1, read_enable_b_n = 1'b1, output_drive_enable_n = 1'b0;
   logic [3:0] almost_empty_offset = 4'h2, almost_full_offset = 4'h3;
   logic [DATA_W-1:0] word = 9'h0a5, data_in, data_out, last = 9'h000;
   logic [DATA_W-1:0] q[$];
   logic write_side_clock, read_side_clock, data_out_oe, empty_flag_n, full_flag_n;
   logic almost_empty_flag_n, almost_full_flag_n, offset_load_mode;
   int num_errors = 0, total_checks = 0;
   wire [3:0] flags = {empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n};
   always #5 clk = ~clk;
   pin_partner partner (.write_side_clock, .read_side_clock, .write_enable_primary_n, .word,
      .data_in);
   dual_clock_fifo_with_flags #(.DEPTH(16)) DUT (.clk, .rst, .ce, .write_side_clock,
      .read_side_clock, .data_in, .write_enable_primary_n, .write_enable_or_load,
      .read_enable_a_n, .read_enable_b_n, .reset_n, .output_drive_enable_n, .offset_load,
      .almost_empty_offset, .almost_full_offset, .data_out, .data_out_oe, .empty_flag_n,
      .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .offset_load_mode);
   task test_done;
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Writes held back to back; a word past full is not kept
   task put(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge write_side_clock);
         @(negedge clk);
         word = word + 9'h0c7;
         write_enable_primary_n = 1'b0;
         if (q.size() < 16) q.push_back(word);
      end
      @(negedge write_side_clock);
      @(negedge clk);
      write_enable_primary_n = 1'b1;
   endtask
   // One enable as system control, the other as steering
   task take(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge read_side_clock);
         @(negedge clk);
         read_enable_a_n = 1'b0;
         read_enable_b_n = 1'b0;
         @(posedge read_side_clock);
         repeat (5) @(negedge clk);
         if (q.size() > 0) last = q.pop_front();
         chk(data_out, last);
      end
      @(negedge clk);
      read_enable_a_n = 1'b1;
      read_enable_b_n = 1'b1;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      repeat (40) @(negedge clk);
      chk(flags, 4'h3);
      chk(data_out, 9'h000);
      // A load strobe in the dual-enable role must leave the defaults alone
      offset_load = 1'b1;
      @(negedge clk);
      offset_load = 1'b0;
      foreach (rows[k]) begin
         fork
            put(rows[k].nw);
            take(rows[k].nr);
         join
         repeat (40) @(negedge clk);
         chk(flags, rows[k].fl);
      end
      output_drive_enable_n = 1'b1;
      repeat (6) @(negedge clk);
      chk(data_out_oe, 1'b0);
      output_drive_enable_n = 1'b0;
      repeat (6) @(negedge clk);
      chk(data_out_oe, 1'b1);
      // Reset with data inside, taking the load role
      put(3);
      write_enable_or_load = 1'b0;
      reset_n = 1'b0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      q.delete();
      last = 9'h000;
      repeat (10) @(negedge clk);
      write_enable_or_load = 1'b1;
      chk(offset_load_mode, 1'b1);
      chk(flags, 4'h3);
      chk(data_out, 9'h000);
      almost_empty_offset = 4'h2;
      almost_full_offset = 4'h3;
      offset_load = 1'b1;
      @(negedge clk);
      offset_load = 1'b0;
      put(3);
      repeat (40) @(negedge clk);
      chk(flags, 4'hf);
      // Ten words: the default would show almost full, an offset of three not
      put(7);
      repeat (40) @(negedge clk);
      chk(flags, 4'hf);
      put(3);
      repeat (40) @(negedge clk);
      chk(flags, 4'hd);
      take(3);
      test_done();
   end
   // Cuts a hang short
   initial begin
      repeat (50000) @(posedge clk);
      num_errors++;
      test_done();
   end
endmodule

// file: verif/fifo_chk.sv
// Checker on the top ports of the buffer.
// Assumes pin clocks far slower than clk.
`timescale 1ns/10ps
module fifo_chk
   import fifo_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic write_side_clock,
   input wire logic read_side_clock,
   input wire logic write_enable_or_load,
   input wire logic reset_n,
   input wire logic output_drive_enable_n,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_out_oe,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic almost_empty_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic offset_load_mode
);
   logic rclk_r, wclk_r;
   logic [3:0] rage_r, wage_r, quiet_r;
   // Ages since pin clock rises and since reset_n went high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rclk_r <= 1'b0;
         wclk_r <= 1'b0;
         rage_r <= 4'hf;
         wage_r <= 4'hf;
         quiet_r <= 4'h0;
      end else begin
         rclk_r <= read_side_clock;
         wclk_r <= write_side_clock;
         rage_r <= (read_side_clock && !rclk_r) ? 4'h0 : rage_r + {3'h0, rage_r != 4'hf};
         wage_r <= (write_side_clock && !wclk_r) ? 4'h0 : wage_r + {3'h0, wage_r != 4'hf};
         quiet_r <= !reset_n ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Role capture needs a steady level across the synchroniser
   sequence s_role; (!reset_n && $stable(write_enable_or_load))[*4]; endsequence
   sequence s_oe_off; output_drive_enable_n[*5]; endsequence
   a_empty_rclk: assert property ($changed(empty_flag_n) && quiet_r == 4'hf
      |-> rage_r <= 4'h6)
      else $error("empty flag moved off a read edge");
   a_aempty_rclk: assert property ($changed(almost_empty_flag_n) && quiet_r == 4'hf
      |-> rage_r <= 4'h6)
      else $error("almost empty moved off a read edge");
   a_full_wclk: assert property ($changed(full_flag_n) && quiet_r == 4'hf
      |-> wage_r <= 4'h6)
      else $error("full flag moved off a write edge");
   a_afull_wclk: assert property ($changed(almost_full_flag_n) && quiet_r == 4'hf
      |-> wage_r <= 4'h6)
      else $error("almost full moved off a write edge");
   a_data_rclk: assert property ($changed(data_out) && quiet_r == 4'hf
      |-> rage_r <= 4'h6)
      else $error("output word moved off a read edge");
   a_flag_hold: assert property ($changed(empty_flag_n) && quiet_r == 4'hf
      |=> $stable(empty_flag_n)[*8])
      else $error("empty flag did not hold");
   // Write edges come every sixteen clk cycles, so eight is well inside
   a_full_hold: assert property ($changed(full_flag_n) && quiet_r == 4'hf
      |=> $stable(full_flag_n)[*8])
      else $error("full flag did not hold");
   a_oe_off: assert property (s_oe_off |-> !data_out_oe)
      else $error("output driven while disabled");
   a_role_latch: assert property (s_role
      |=> offset_load_mode == !$past(write_enable_or_load))
      else $error("role not taken during reset");
endmodule
bind dual_clock_fifo_with_flags fifo_chk chk (.clk, .rst, .write_side_clock, .read_side_clock,
   .write_enable_or_load, .reset_n, .output_drive_enable_n, .data_out, .data_out_oe,
   .empty_flag_n, .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n, .offset_load_mode);

// file: verif/pin_partner.sv
// Writer and reader pin side: free-running pin clocks and the data bus.
// Assumes the bench owns the enables and the word to be written.
`timescale 1ns/10ps
module pin_partner
   import fifo_pkg::*;
(
   output logic write_side_clock,
   output logic read_side_clock,
   input wire logic write_enable_primary_n,
   input wire logic [DATA_W-1:0] word,
   output logic [DATA_W-1:0] data_in
);
   // Periods differ so the two phases drift apart
   initial write_side_clock = 1'b0;
   initial read_side_clock = 1'b0;
   always #80 write_side_clock = ~write_side_clock;
   always #88 read_side_clock = ~read_side_clock;
   // Idle bus shows the inverse, so a stale word is never caught
   assign data_in = write_enable_primary_n ? ~word : word;
endmodule

// file: verilog/dual_clock_fifo_with_flags.sv
// Nine-bit first-in first-out buffer with a write port and a read port,
// each governed by its own pin clock, and four active-low status flags.
// Assumes both pin clocks are well below half of clk; they are sampled
// by clk and their rising edges found, so all state lives on clk.
`timescale 1ns/10ps
module dual_clock_fifo_with_flags
   import fifo_pkg::*;
#(
   parameter int DEPTH = DEPTH_16K
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic write_side_clock,
   input wire logic read_side_clock,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic write_enable_primary_n,
   input wire logic write_enable_or_load,
   input wire logic read_enable_a_n,
   input wire logic read_enable_b_n,
   input wire logic reset_n,
   input wire logic output_drive_enable_n,
   input wire logic offset_load,
   input wire logic [$clog2(DEPTH)-1:0] almost_empty_offset,
   input wire logic [$clog2(DEPTH)-1:0] almost_full_offset,
   output logic [DATA_W-1:0] data_out,
   output logic data_out_oe,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic almost_empty_flag_n,
   output logic almost_full_flag_n,
   output logic offset_load_mode
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] OFFSET_RST = AW'(DEFAULT_OFFSET);

   // ---------------------------------------------------------------
   // Pin sampling
   // ---------------------------------------------------------------
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins;
   logic wclk_d_r;
   logic rclk_d_r;
   logic wr_edge;
   logic rd_edge;
   logic dev_reset;

   // Every pin but offset_load and the two offset buses, clocks included, passes two flops before use
   assign pins_raw = {data_in, write_enable_primary_n, write_enable_or_load, read_enable_a_n,
      read_enable_b_n, write_side_clock, read_side_clock, reset_n, output_drive_enable_n};

   sync_two_ff #(
      .W(PIN_W)
   ) pin_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(pins_raw),
      .dout(pins)
   );

   // Edge finders look at the synchronised copies only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wclk_d_r <= 1'b0;
         rclk_d_r <= 1'b0;
      end else if (ce) begin
         wclk_d_r <= pins[PIN_WCLK];
         rclk_d_r <= pins[PIN_RCLK];
      end
   end

   // Rising pin-clock edges, with tied clocks both fire together
   assign wr_edge = ce && pins[PIN_WCLK] && !wclk_d_r;
   assign rd_edge = ce && pins[PIN_RCLK] && !rclk_d_r;
   assign dev_reset = !pins[PIN_RST];

   // ---------------------------------------------------------------
   // Mode and thresholds
   // ---------------------------------------------------------------
   mode_type mode_r;
   logic [AW-1:0] ae_off_r;
   logic [AW-1:0] af_off_r;

   // Role of the second enable follows its level while reset is held
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_r <= mode_dual_enable;
      end else if (ce && dev_reset) begin
         mode_r <= pins[PIN_WEN2] ? mode_dual_enable : mode_offset_load;
      end
   end

   // Thresholds load only in load role; reset restores defaults
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ae_off_r <= OFFSET_RST;
         af_off_r <= OFFSET_RST;
      end else if (ce) begin
         if (dev_reset) begin
            ae_off_r <= OFFSET_RST;
            af_off_r <= OFFSET_RST;
         end else if (offset_load && mode_r == mode_offset_load) begin
            ae_off_r <= almost_empty_offset;
            af_off_r <= almost_full_offset;
         end
      end
   end

   // ---------------------------------------------------------------
   // Storage and positions
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mem_r [DEPTH];
   logic [AW:0] wptr_r;
   logic [AW:0] rptr_r;
   logic [AW:0] wptr_nxt;
   logic [AW:0] rptr_nxt;
   logic [AW:0] count_nxt;
   logic wr_go;
   logic rd_go;

   // Both roles need the primary enable low and the second pin high;
   // a low second pin blocks the data write in either role; offsets load on offset_load
   assign wr_go = wr_edge && !dev_reset && !pins[PIN_WRITE_ENABLE_PRIMARY_N] && pins[PIN_WEN2]
      && full_flag_n;
   assign rd_go = rd_edge && !dev_reset && !pins[PIN_RENA] && !pins[PIN_RENB]
      && empty_flag_n;

   assign wptr_nxt = wr_go ? wptr_r + 1'b1 : wptr_r;
   assign rptr_nxt = rd_go ? rptr_r + 1'b1 : rptr_r;
   // Both positions share clk, so the fill level is exact, never stale
   assign count_nxt = wptr_nxt - rptr_nxt;

   // Word store, one flop row per entry
   always_ff @(posedge clk) begin
      if (wr_go) begin
         mem_r[wptr_r[AW-1:0]] <= pins[PIN_DATA +: DATA_W];
      end
   end

   // Write position: reset empties, full holds it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_r <= '0;
      end else if (ce) begin
         if (dev_reset) begin
            wptr_r <= '0;
         end else begin
            wptr_r <= wptr_nxt;
         end
      end
   end

   // Read position and output word; output clears on reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rptr_r <= '0;
         data_out <= '0;
      end else if (ce) begin
         if (dev_reset) begin
            rptr_r <= '0;
            data_out <= '0;
         end else if (rd_go) begin
            rptr_r <= rptr_nxt;
            data_out <= mem_r[rptr_r[AW-1:0]];
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   // Read-side flags move only on read edges. A write alone cannot clear
   // empty until the next read edge, which is late but never false
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         empty_flag_n <= 1'b0;
         almost_empty_flag_n <= 1'b0;
      end else if (ce) begin
         if (dev_reset) begin
            empty_flag_n <= 1'b0;
            almost_empty_flag_n <= 1'b0;
         end else if (rd_edge) begin
            empty_flag_n <= count_nxt != '0;
            almost_empty_flag_n <= count_nxt > {1'b0, ae_off_r};
         end
      end
   end

   // Write-side flags move only on write edges; only writes fill
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         full_flag_n <= 1'b1;
         almost_full_flag_n <= 1'b1;
      end else if (ce) begin
         if (dev_reset) begin
            full_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
         end else if (wr_edge) begin
            full_flag_n <= count_nxt != DEPTH_CNT;
            almost_full_flag_n <= count_nxt < DEPTH_CNT - {1'b0, af_off_r};
         end
      end
   end

   // ---------------------------------------------------------------
   // Output drive and mode report
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_out_oe <= 1'b0;
         offset_load_mode <= 1'b0;
      end else if (ce) begin
         data_out_oe <= !pins[PIN_OE];
         offset_load_mode <= mode_r == mode_offset_load;
      end
   end
endmodule

// file: verilog/fifo_pkg.sv
// Shared constants and types for the nine-bit dual-clock buffer.
// Assumes every design file but sync_two_ff imports the whole package.
package fifo_pkg;
   // ---------------------------------------------------------------
   // Word and depth
   // ---------------------------------------------------------------
   localparam int DATA_W = 9;
   localparam int DEPTH_16K = 16384;
   localparam int DEPTH_64K = 65536;
   localparam int DEPTH_128K = 131072;
   // ---------------------------------------------------------------
   // Flag thresholds after reset, in words from empty or full
   // ---------------------------------------------------------------
   localparam int DEFAULT_OFFSET = 7;
   // ---------------------------------------------------------------
   // Pin synchroniser: data, two write enables, two read enables,
   // write clock, read clock, reset, output enable
   // ---------------------------------------------------------------
   localparam int PIN_W = DATA_W + 8;
   localparam int PIN_OE = 0;
   localparam int PIN_RST = 1;
   localparam int PIN_RCLK = 2;
   localparam int PIN_WCLK = 3;
   localparam int PIN_RENB = 4;
   localparam int PIN_RENA = 5;
   localparam int PIN_WEN2 = 6;
   localparam int PIN_WRITE_ENABLE_PRIMARY_N = 7;
   localparam int PIN_DATA = 8;
   // Role of the second write enable, caught during reset
   typedef enum logic {
      mode_dual_enable,
      mode_offset_load
   } mode_type;
endpackage

// file: verilog/sync_two_ff.sv
// Two-stage synchroniser for a bundle of independent levels.
// Assumes each bit is a level that may change at any time.
`timescale 1ns/10ps
module sync_two_ff #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         dout <= '0;
      end else if (ce) begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule
